// [shared/dpo_pkg.sv]
// Package for the oscillator pull control register bank
package dpo_pkg;

  localparam int unsigned REG_W         = 16;
  localparam int unsigned OFS_W         = 26;
  localparam int unsigned UPPER_W       = 10;
  localparam int unsigned RANGE_W       = 4;
  localparam int unsigned PPM_W         = 19;

  localparam logic [7:0] ADDR_LOWER     = 8'h00;
  localparam logic [7:0] ADDR_UPPER     = 8'h01;
  localparam logic [7:0] ADDR_RANGE     = 8'h02;

  localparam int unsigned OE_BIT        = 10;
  localparam int unsigned UPPER_LSB     = 0;
  localparam int unsigned RANGE_LSB     = 0;

  localparam logic [15:0] LOWER_RST     = 16'h0000;
  localparam logic [15:0] UPPER_RST     = 16'h0000;
  localparam logic [25:0] OFS_RST       = 26'h0000000;
  localparam logic [3:0]  RANGE_RST     = 4'h0;

  // Register strobe from the serial slave
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dpo_req_s;

  // Read answer back to the serial slave
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } dpo_rsp_s;

  // Settings that drive the oscillator core
  typedef struct packed {
    logic [25:0] pull_offset_word;
    logic        out_enable;
    logic [18:0] half_range_cppm;
    logic        offset_load;
  } dpo_ctl_s;

endpackage

// [rtl/dpo_range_decode.sv]
// Pull range code to half range, in hundredths of a ppm
`timescale 1ns/1ps
`default_nettype none
module dpo_range_decode
  import dpo_pkg::*;
(
  // Code in
  input  wire logic [dpo_pkg::RANGE_W-1:0] code,
  // Half range out
  output logic      [dpo_pkg::PPM_W-1:0]   half_range_cppm
);
  always_comb
  begin
    unique case (code)
      4'h0: half_range_cppm = 19'h00271;
      4'h1: half_range_cppm = 19'h003e8;
      4'h2: half_range_cppm = 19'h004e2;
      4'h3: half_range_cppm = 19'h009c4;
      4'h4: half_range_cppm = 19'h01388;
      4'h5: half_range_cppm = 19'h01f40;
      4'h6: half_range_cppm = 19'h02710;
      4'h7: half_range_cppm = 19'h030d4;
      4'h8: half_range_cppm = 19'h03a98;
      4'h9: half_range_cppm = 19'h04e20;
      4'ha: half_range_cppm = 19'h09c40;
      4'hb: half_range_cppm = 19'h0ea60;
      4'hc: half_range_cppm = 19'h13880;
      4'hd: half_range_cppm = 19'h1d4c0;
      4'he: half_range_cppm = 19'h27100;
      4'hf: half_range_cppm = 19'h4e200;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/dpo_regs.sv]
// Register bank for the digitally pulled oscillator
// Operation
// - Upper register bits 15:11 read zero, ignored
// - Bit 10 enables output, reset disabled
// - Software enable acts only in software mode
// - Offset is upper ten plus lower sixteen
// - Offset word is zero after reset
// - Offset word is signed two's complement
// - Only upper write applies a new offset
// - Range code selects sixteen ppm ranges
// - Range register bits 15:4 read zero
// - Range loads factory value after reset, rewritable
// - Registers travel as two bytes, MSB first
`timescale 1ns/1ps
`default_nettype none
module dpo_regs
  import dpo_pkg::*;
#(
  parameter logic [3:0] FACTORY_RANGE = dpo_pkg::RANGE_RST
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Register strobes from the serial slave
  input  wire dpo_pkg::dpo_req_s req,
  output var dpo_pkg::dpo_rsp_s rsp,
  // Enable pin and its mode
  input  wire logic             sw_oe_mode,
  input  wire logic             oe_pin,
  // Oscillator core control
  output var dpo_pkg::dpo_ctl_s ctl
);
  import dpo_pkg::*;

  typedef struct packed {
    logic [15:0] lower_offset_part;
    logic [9:0]  upper_offset_part;
    logic        oe_soft;
    logic [3:0]  range_code;
    logic        range_loaded;
    dpo_rsp_s    rsp;
    dpo_ctl_s    ctl;
  } dpo_state_s;

  dpo_state_s  st_q;
  dpo_state_s  st_d;
  logic [PPM_W-1:0]   half_range;
  logic [RANGE_W-1:0] range_next;

  // Decode runs on the next code so the registered half range and code move together
  dpo_range_decode u_decode (
    .code            (range_next),
    .half_range_cppm (half_range)
  );

  // Next range code, kept apart from the state update to avoid a loop through the decoder
  // factory load last so it wins
  always_comb
  begin
    range_next = st_q.range_code;
    if (req.wr && req.addr == ADDR_RANGE)
    begin
      range_next = req.wdata[RANGE_LSB +: RANGE_W];
    end
    // A write in the first cycle after reset loses to the factory code
    if (!st_q.range_loaded)
    begin
      range_next = FACTORY_RANGE;
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.ctl.offset_load = 1'b0;
    st_d.rsp.valid = 1'b0;
    if (req.wr)
    begin
      unique case (req.addr)
        ADDR_LOWER:
        begin
          st_d.lower_offset_part = req.wdata;
        end
        ADDR_UPPER:
        begin
          st_d.upper_offset_part = req.wdata[UPPER_LSB +: UPPER_W];
          st_d.oe_soft = req.wdata[OE_BIT];
          st_d.ctl.pull_offset_word = {req.wdata[UPPER_LSB +: UPPER_W],
                                       st_q.lower_offset_part};
          st_d.ctl.offset_load = 1'b1;
        end
        ADDR_RANGE:
        begin
          st_d.range_code = range_next;
        end
        default:
        begin
          st_d.ctl.offset_load = 1'b0;
        end
      endcase
    end
    if (req.rd)
    begin
      st_d.rsp.valid = 1'b1;
      unique case (req.addr)
        ADDR_LOWER: st_d.rsp.rdata = st_q.lower_offset_part;
        ADDR_UPPER: st_d.rsp.rdata = {5'h00, st_q.oe_soft, st_q.upper_offset_part};
        ADDR_RANGE: st_d.rsp.rdata = {12'h000, st_q.range_code};
        default:    st_d.rsp.rdata = 16'h0000;
      endcase
    end
    st_d.ctl.out_enable = sw_oe_mode ? st_d.oe_soft : oe_pin;
    st_d.ctl.half_range_cppm = half_range;
    st_d.range_loaded = 1'b1;
    st_d.range_code = range_next;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.ctl.pull_offset_word <= OFS_RST;
      st_q.lower_offset_part <= LOWER_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rsp = st_q.rsp;
  assign ctl = st_q.ctl;

  a_lower_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_LOWER) |=> $stable(ctl.pull_offset_word))
    else $error("lower write changed offset");
  a_upper_applies: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_UPPER) |=>
      ctl.pull_offset_word == {$past(req.wdata[9:0]), $past(st_q.lower_offset_part)}
      && ctl.offset_load)
    else $error("upper write not applied");
  a_upper_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (req.rd && req.addr == ADDR_UPPER) |=> rsp.rdata[15:11] == 5'h00)
    else $error("upper unused bits not zero");
  a_range_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (req.rd && req.addr == ADDR_RANGE) |=> rsp.rdata[15:4] == 12'h000)
    else $error("range unused bits not zero");
  a_pin_mode: assert property (@(posedge clock) disable iff (!rst_n)
    !sw_oe_mode |=> ctl.out_enable == $past(oe_pin))
    else $error("pin mode enable wrong");
  a_soft_oe: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_oe_mode && req.wr && req.addr == ADDR_UPPER) |=>
      ctl.out_enable == $past(req.wdata[10]))
    else $error("software enable wrong");
  a_reset_zero: assert property (@(posedge clock)
    !rst_n |=> ctl.pull_offset_word == 26'h0000000)
    else $error("offset not zero after reset");
  a_range_top: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_RANGE && req.wdata[3:0] == 4'hf && st_q.range_loaded) |=>
      ctl.half_range_cppm == 19'h4e200)
    else $error("range code decode wrong");
  a_range_low: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_RANGE && req.wdata[3:0] == 4'h0 && st_q.range_loaded) |=>
      ctl.half_range_cppm == 19'h00271)
    else $error("range code zero decode wrong");
  a_offset_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !(req.wr && req.addr == ADDR_UPPER) |=> $stable(ctl.pull_offset_word))
    else $error("offset moved without upper write");
  a_load_source: assert property (@(posedge clock) disable iff (!rst_n)
    ctl.offset_load |-> $past(req.wr && req.addr == ADDR_UPPER))
    else $error("load pulse without upper write");
  a_lower_place: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_LOWER) |=> st_q.lower_offset_part == $past(req.wdata))
    else $error("lower part not held");
  a_sign_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_UPPER) |=> ctl.pull_offset_word[25] == $past(req.wdata[9]))
    else $error("offset sign bit wrong");
  a_oe_stored: assert property (@(posedge clock) disable iff (!rst_n)
    (req.wr && req.addr == ADDR_UPPER) |=> st_q.oe_soft == $past(req.wdata[10]))
    else $error("enable bit not stored");
  a_soft_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_oe_mode && !(req.wr && req.addr == ADDR_UPPER)) |=>
      ctl.out_enable == $past(st_q.oe_soft))
    else $error("software enable moved");
  a_read_answer: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd |=> rsp.valid)
    else $error("read not answered");
  a_read_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    !req.rd |=> !rsp.valid)
    else $error("answer without read");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (req.rd && req.addr > ADDR_RANGE) |=> rsp.rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_lower_read: assert property (@(posedge clock) disable iff (!rst_n)
    (req.rd && req.addr == ADDR_LOWER) |=> rsp.rdata == $past(st_q.lower_offset_part))
    else $error("lower readback wrong");
  a_range_read: assert property (@(posedge clock) disable iff (!rst_n)
    (req.rd && req.addr == ADDR_RANGE) |=> rsp.rdata[3:0] == $past(st_q.range_code))
    else $error("range readback wrong");
  a_range_keep: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.range_loaded && !(req.wr && req.addr == ADDR_RANGE)) |=>
      $stable(st_q.range_code))
    else $error("range code moved");
  a_factory_load: assert property (@(posedge clock) disable iff (!rst_n)
    !st_q.range_loaded |=> st_q.range_code == FACTORY_RANGE)
    else $error("factory range not loaded");
  a_reset_quiet: assert property (@(posedge clock)
    !rst_n |=> !ctl.offset_load && !rsp.valid && !ctl.out_enable)
    else $error("strobes active after reset");
endmodule
`default_nettype wire

// [testbench/dpo_master_model.sv]
// Master-side model that issues register strobes
`timescale 1ns/1ps
`default_nettype none
module dpo_master_model
  import dpo_pkg::*;
(
  // Clock and strobes
  input  wire logic         clock,
  output var dpo_pkg::dpo_req_s req
);
  initial req = '0;
  // Word from two bytes, MSB first
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] hi, input logic [7:0] lo);
    req = '{wr: w, rd: r, addr: a, wdata: {hi, lo}};
    @(posedge clock);
    #1;
  endtask
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_dpo_regs.sv]
// Self-checking bench for the oscillator pull register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dpo_regs;
  import dpo_pkg::*;
  localparam logic [3:0] FACT = 4'h5;
  localparam int         GAP  = 3290;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        sw_oe_mode = 1'b1;
  logic        oe_pin = 1'b0;
  dpo_req_s    req;
  dpo_rsp_s    rsp;
  dpo_ctl_s    ctl;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [15:0] rd_q[$];
  logic [26:0] ld_q[$];
  logic [15:0] lo;
  logic [15:0] up;
  logic [25:0] last;
  logic [18:0] ppm [16] = '{19'h271, 19'h3e8, 19'h4e2, 19'h9c4, 19'h1388, 19'h1f40,
    19'h2710, 19'h30d4, 19'h3a98, 19'h4e20, 19'h9c40, 19'hea60, 19'h13880, 19'h1d4c0,
    19'h27100, 19'h4e200};
  dpo_master_model i_mst (.clock(clock), .req(req));
  dpo_regs #(.FACTORY_RANGE(FACT)) i_dut (.clock(clock), .rst_n(rst_n), .req(req),
    .rsp(rsp), .sw_oe_mode(sw_oe_mode), .oe_pin(oe_pin), .ctl(ctl));
  initial forever #4 clock = ~clock;
  task automatic cmp(input string what, input logic [26:0] exp, input logic [26:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("TB: checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_mst.xfer(1'b1, 1'b0, a, d[15:8], d[7:0]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    i_mst.xfer(1'b0, 1'b1, a, 8'h00, 8'h00);
  endtask
  // Watcher and cycle ceiling
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      close_out();
    end
    if (rsp.valid === 1'b1)
      cmp("rdata", {11'h0, rd_q.pop_front()}, {11'h0, rsp.rdata});
    if (ctl.offset_load === 1'b1)
      cmp("load", ld_q.pop_front(), {ctl.out_enable, ctl.pull_offset_word});
  end
  initial
  begin
    void'($urandom(42));
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    cmp("reset", 27'h0, {ctl.out_enable, ctl.pull_offset_word});
    cmp("ppm", 27'(ppm[FACT]), 27'(ctl.half_range_cppm));
    rd(ADDR_UPPER, 16'h0000);
    rd(ADDR_RANGE, {12'h0, FACT});
    rd(8'h03, 16'h0000);
    $display("TB: reset test done");
    for (int c = 0; c < 16; c++)
    begin
      up = 16'($urandom());
      wr(ADDR_RANGE, {up[15:4], 4'(c)});
      rd(ADDR_RANGE, {12'h0, 4'(c)});
      cmp("ppm", 27'(ppm[c]), 27'(ctl.half_range_cppm));
    end
    $display("TB: range test done");
    for (int i = 0; i < 24; i++)
    begin
      sw_oe_mode = (i < 16);
      oe_pin = 1'($urandom());
      // First word is minus a quarter of the half range
      lo = (i == 0) ? 16'h0000 : 16'($urandom());
      up = (i == 0) ? 16'hfb80 : 16'($urandom());
      // Keep output on across some changes
      if (sw_oe_mode && i[0])
        up[10] = 1'b1;
      i_mst.idle(GAP);
      last = ctl.pull_offset_word;
      wr(ADDR_LOWER, lo);
      rd(ADDR_LOWER, lo);
      cmp("held", 27'(last), 27'(ctl.pull_offset_word));
      ld_q.push_back({sw_oe_mode ? up[10] : oe_pin, up[9:0], lo});
      wr(ADDR_UPPER, up);
      rd(ADDR_UPPER, up & 16'h07ff);
    end
    i_mst.xfer(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    cmp("pending", 27'h0, 27'(rd_q.size() + ld_q.size()));
    $display("TB: offset test done");
    close_out();
  end
endmodule
`default_nettype wire
